/* File: rtl/rfws_debounce.sv */
// pushbutton debouncer sampled at the slow debounce rate
`timescale 1ns/1ps
`default_nettype none

module rfws_debounce
(
	// clock and reset
	input  wire logic hclk,
	input  wire logic hresetn,
	input  wire logic ce,
	// sampling
	input  wire logic sample_en,
	input  wire logic level_in,
	input  wire logic block_in,
	// result
	output var  logic rise_r
);
	import rfws_pkg::*;

	rfws_deb_type state_r;

	// a level must be seen on two samples in a row, so a pulse shorter
	// than one sample period never passes and one under two may not
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			state_r <= DB_LOW;
			rise_r  <= 1'b0;
		end
		else if (ce)
		begin
			rise_r <= 1'b0;
			if (sample_en)
			begin
				case (state_r)
					DB_LOW:  state_r <= level_in ? DB_PEND : DB_LOW;
					DB_PEND:
					begin
						state_r <= level_in ? DB_HIGH : DB_LOW;
						rise_r  <= level_in & ~block_in;
					end
					DB_HIGH: state_r <= level_in ? DB_HIGH : DB_LOW;
					default: state_r <= DB_LOW;
				endcase
			end
		end
	end
endmodule

`default_nettype wire

/* File: rtl/rfws_defines.svh */
// offsets, field positions, reset values and timing counts of the sequencer
`ifndef RFWS_DEFINES_SVH
`define RFWS_DEFINES_SVH

// register byte offsets
`define RFWS_CTRL_OFS        8'h00
`define RFWS_STATUS_OFS      8'h04
`define RFWS_FLAGS_OFS       8'h08

// control register fields
`define RFWS_CTRL_ARM        0
`define RFWS_CTRL_RES        1
`define RFWS_CTRL_PRD_LO     2
`define RFWS_CTRL_PRD_HI     4
`define RFWS_CTRL_SLEEP      5
`define RFWS_CTRL_DISP       6
`define RFWS_CTRL_DIV_LO     8
`define RFWS_CTRL_DIV_HI     10
`define RFWS_CTRL_RST        32'h0000_0000

// status register fields
`define RFWS_STAT_MODE_LO    0
`define RFWS_STAT_MODE_HI    2
`define RFWS_STAT_PLL        3
`define RFWS_STAT_CMP        4
`define RFWS_STAT_BAT        5
`define RFWS_STAT_ARMED      6

// flag register fields, write one to clear
`define RFWS_FLAG_BTN        0
`define RFWS_FLAG_TMR        1
`define RFWS_FLAG_RET        2

// timing, in crystal cycles unless a unit is named
`define RFWS_CRYSTAL_HZ      32768
`define RFWS_RESET_TICKS     4100
`define RFWS_NOPWR_TICKS     2
`define RFWS_PLL_MIN_TICKS   2048
`define RFWS_PLL_MAX_TICKS   4096
`define RFWS_DEB_HZ          32
`define RFWS_DEB_TICKS       (`RFWS_CRYSTAL_HZ / `RFWS_DEB_HZ)
`define RFWS_WAKE_SHORT_MS   2500
`define RFWS_WAKE_LONG_MS    60000
`define RFWS_WAKE_SHORT_TICKS (`RFWS_WAKE_SHORT_MS * `RFWS_CRYSTAL_HZ / 1000)
`define RFWS_WAKE_LONG_TICKS  (`RFWS_WAKE_LONG_MS * `RFWS_CRYSTAL_HZ / 1000)

`endif

/* File: rtl/rfws_pkg.sv */
// types shared by the sequencer files
`default_nettype none

package rfws_pkg;
	// operating modes of the sequencer
	typedef enum logic [2:0] {
		ST_RESET,
		ST_FULL,
		ST_BATT,
		ST_DISP,
		ST_SLEEP
	} rfws_state_type;

	// pushbutton debounce states
	typedef enum logic [1:0] {
		DB_LOW,
		DB_PEND,
		DB_HIGH
	} rfws_deb_type;
endpackage

`default_nettype wire

/* File: rtl/rfws_sequencer.sv */
// reset, power-fault and wake sequencer with its ahb-lite register slave
//
// Local design decisions: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "rfws_defines.svh"

// Operation
// - reset pin high forces defaults, halts
// - power present: run after 4100 crystal ticks
// - no power: run after 2 ticks, battery
// - fault clears pll lock, battery run
// - fault without battery drops run, sleeps
// - full power waits for pll lock
// - battery to full raises interrupt, keeps config
// - wake from low modes shows reset config
// - watchdog on when full from low modes
// - button rise wakes, sets button flag
// - button debounced at 32 Hz samples
// - further presses ignored until flag cleared
// - timer expiry wakes, sets timer flag
// - timer unit one minute or 2.5 s
// - period field gives 1 to 7 units
// - arming loads timer, request starts it
// - timer cleared and disarmed on wake
// - battery run: slow clock, divider ignored
// - no flag and power: power restored
module rfws_sequencer
#(
	parameter int unsigned RESET_TICKS      = `RFWS_RESET_TICKS,
	parameter int unsigned PLL_SETTLE_TICKS = `RFWS_PLL_MIN_TICKS,
	parameter int unsigned DEB_TICKS        = `RFWS_DEB_TICKS,
	parameter int unsigned WAKE_SHORT_TICKS = `RFWS_WAKE_SHORT_TICKS,
	parameter int unsigned WAKE_LONG_TICKS  = `RFWS_WAKE_LONG_TICKS
)
(
	// clock, reset and clock enable
	input  wire logic                    hclk,
	input  wire logic                    hresetn,
	input  wire logic                    ce,
	// ahb-lite slave
	input  wire logic                    hsel,
	input  wire logic [31:0]             haddr,
	input  wire logic [1:0]              htrans,
	input  wire logic                    hwrite,
	input  wire logic [2:0]              hsize,
	input  wire logic [31:0]             hwdata,
	input  wire logic                    hready,
	output var  logic [31:0]             hrdata,
	output var  logic                    hreadyout,
	output var  logic                    hresp,
	// device pins
	input  wire logic                    reset_pin,
	input  wire logic                    fault_sense_input,
	input  wire logic                    battery_good_flag,
	input  wire logic                    pushbutton_input,
	input  wire logic                    slow_crystal_clock,
	// processor and system controls
	output var  logic                    run_r,
	output var  logic                    cpu_start_r,
	output var  rfws_pkg::rfws_state_type mode_r,
	output var  logic                    pll_locked_r,
	output var  logic                    watchdog_en_r,
	output var  logic                    cpu_slow_clk_r,
	output var  logic [2:0]              cpu_div_r,
	output var  logic                    power_return_irq_r
);
	import rfws_pkg::*;

	localparam logic [12:0] RST_LONG  = 13'(RESET_TICKS - 1);
	localparam logic [12:0] RST_SHORT = 13'(`RFWS_NOPWR_TICKS - 1);
	localparam logic [12:0] PLL_LIM   = 13'(PLL_SETTLE_TICKS - 1);
	localparam logic [9:0]  DEB_LIM   = 10'(DEB_TICKS - 1);
	localparam logic [20:0] UNIT_S    = 21'(WAKE_SHORT_TICKS - 1);
	localparam logic [20:0] UNIT_L    = 21'(WAKE_LONG_TICKS - 1);

	logic [4:0]     sync1_r;
	logic [4:0]     sync2_r;
	logic           xtal_prev_r;
	logic           tick;
	logic           pin_s;
	logic           pwr_s;
	logic           bat_s;
	logic [9:0]     deb_cnt_r;
	logic           tick32;
	logic           btn_rise;
	logic [12:0]    rst_cnt_r;
	logic           rst_done;
	logic [12:0]    pll_cnt_r;
	rfws_state_type state_nxt;
	logic           run_nxt;
	logic           wake_edge;
	logic           low_mode;
	logic           enter_low;
	logic           btn_evt;
	logic           tmr_evt;
	logic           res_r;
	logic [2:0]     prd_r;
	logic [2:0]     div_r;
	logic           armed_r;
	logic           tmr_res_r;
	logic [2:0]     tmr_unit_r;
	logic [20:0]    tmr_sub_r;
	logic           btn_flag_r;
	logic           tmr_flag_r;
	logic           ap_valid_r;
	logic           ap_write_r;
	logic [7:0]     ap_addr_r;
	logic           take;
	logic           wr_ctrl;
	logic           wr_flags;
	logic           req_sleep;
	logic           req_disp;
	logic [31:0]    rd_data;

	// two-flop synchronisers for every pin; the crystal is one of them
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			sync1_r     <= 5'h00;
			sync2_r     <= 5'h00;
			xtal_prev_r <= 1'b0;
		end
		else if (ce)
		begin
			sync1_r     <= {slow_crystal_clock, pushbutton_input,
				battery_good_flag, fault_sense_input, reset_pin};
			sync2_r     <= sync1_r;
			xtal_prev_r <= sync2_r[4];
		end
	end

	assign pin_s = sync2_r[0];
	assign pwr_s = sync2_r[1];
	assign bat_s = sync2_r[2];
	assign tick  = sync2_r[4] & ~xtal_prev_r;

	// 32 Hz sampling strobe derived from crystal ticks
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			deb_cnt_r <= 10'h000;
		else if (ce && tick)
			deb_cnt_r <= (deb_cnt_r == DEB_LIM) ? 10'h000 : deb_cnt_r + 10'h001;
	end

	assign tick32 = tick && (deb_cnt_r == DEB_LIM);

	rfws_debounce u_debounce
	(
		.hclk      (hclk),
		.hresetn   (hresetn),
		.ce        (ce),
		.sample_en (tick32),
		.level_in  (sync2_r[3]),
		.block_in  (btn_flag_r),
		.rise_r    (btn_rise)
	);

	// reset timer: long with system power, two ticks on battery alone
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			rst_cnt_r <= 13'h0000;
		else if (ce)
		begin
			if (pin_s || mode_r != ST_RESET)
				rst_cnt_r <= 13'h0000;
			else if (tick)
				rst_cnt_r <= rst_cnt_r + 13'h0001;
		end
	end

	assign rst_done = (mode_r == ST_RESET) && !pin_s && tick &&
		(rst_cnt_r >= (pwr_s ? RST_LONG : RST_SHORT));

	// pll lock model: settles a fixed number of ticks after power returns
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			pll_cnt_r    <= 13'h0000;
			pll_locked_r <= 1'b0;
		end
		else if (ce)
		begin
			if (!pwr_s)
			begin
				pll_cnt_r    <= 13'h0000;
				pll_locked_r <= 1'b0;
			end
			else if (!pll_locked_r && tick)
			begin
				pll_cnt_r    <= pll_cnt_r + 13'h0001;
				pll_locked_r <= (pll_cnt_r == PLL_LIM);
			end
		end
	end

	assign low_mode = (mode_r == ST_DISP) || (mode_r == ST_SLEEP);
	assign btn_evt  = low_mode && btn_rise;
	assign tmr_evt  = low_mode && armed_r && tick && tmr_unit_r <= 3'h1 &&
		tmr_sub_r == (tmr_res_r ? UNIT_L : UNIT_S);

	// mode selection; the reset pin overrides everything
	always_comb
	begin
		state_nxt = mode_r;
		case (mode_r)
			ST_RESET:
				if (rst_done)
					state_nxt = (pwr_s && pll_locked_r) ? ST_FULL : ST_BATT;
			ST_FULL:
				if (!pwr_s)
					state_nxt = bat_s ? ST_BATT : ST_SLEEP;
			ST_BATT:
				if (!pwr_s && !bat_s)
					state_nxt = ST_SLEEP;
				else if (pwr_s && pll_locked_r)
					state_nxt = ST_FULL;
				else if (req_sleep)
					state_nxt = ST_SLEEP;
				else if (req_disp)
					state_nxt = ST_DISP;
			ST_DISP, ST_SLEEP:
				if (pwr_s && pll_locked_r)
					state_nxt = ST_FULL;
				else if (btn_evt || tmr_evt)
					state_nxt = ST_BATT;
			default:
				state_nxt = ST_RESET;
		endcase
		if (pin_s)
			state_nxt = ST_RESET;
	end

	assign run_nxt   = (state_nxt == ST_FULL) || (state_nxt == ST_BATT);
	assign wake_edge = run_nxt && !run_r;
	assign enter_low = !pin_s && !run_nxt && run_r;

	// mode, run line and the one-cycle start strobe (processor at 00)
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			mode_r      <= ST_RESET;
			run_r       <= 1'b0;
			cpu_start_r <= 1'b0;
		end
		else if (ce)
		begin
			mode_r      <= state_nxt;
			run_r       <= run_nxt;
			cpu_start_r <= wake_edge;
		end
	end

	// watchdog and processor clock selection
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			watchdog_en_r  <= 1'b0;
			cpu_slow_clk_r <= 1'b0;
			cpu_div_r      <= 3'h0;
		end
		else if (ce)
		begin
			if (pin_s || !run_nxt)
				watchdog_en_r <= 1'b0;
			else if (state_nxt == ST_FULL && mode_r != ST_BATT &&
				mode_r != ST_FULL)
				watchdog_en_r <= 1'b1;
			// the stored divider is left alone; only its use is masked
			cpu_slow_clk_r <= (state_nxt == ST_BATT);
			cpu_div_r      <= (state_nxt == ST_FULL) ? div_r : 3'h0;
		end
	end

	// configuration fields; cleared on reset pin and on entry to low modes
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			res_r <= 1'b0;
			prd_r <= 3'h0;
			div_r <= 3'h0;
		end
		else if (ce)
		begin
			if (pin_s || enter_low)
			begin
				res_r <= 1'b0;
				prd_r <= 3'h0;
				div_r <= 3'h0;
			end
			else if (wr_ctrl)
			begin
				res_r <= hwdata[`RFWS_CTRL_RES];
				prd_r <= hwdata[`RFWS_CTRL_PRD_HI:`RFWS_CTRL_PRD_LO];
				div_r <= hwdata[`RFWS_CTRL_DIV_HI:`RFWS_CTRL_DIV_LO];
			end
		end
	end

	// wake timer: preset when armed, counts only in the low modes
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			armed_r    <= 1'b0;
			tmr_res_r  <= 1'b0;
			tmr_unit_r <= 3'h0;
			tmr_sub_r  <= 21'h000000;
		end
		else if (ce)
		begin
			if (pin_s || wake_edge)
			begin
				armed_r    <= 1'b0;
				tmr_unit_r <= 3'h0;
				tmr_sub_r  <= 21'h000000;
			end
			else if (wr_ctrl && hwdata[`RFWS_CTRL_ARM])
			begin
				armed_r    <= 1'b1;
				tmr_res_r  <= hwdata[`RFWS_CTRL_RES];
				tmr_unit_r <= hwdata[`RFWS_CTRL_PRD_HI:`RFWS_CTRL_PRD_LO];
				tmr_sub_r  <= 21'h000000;
			end
			else if (low_mode && armed_r && tick && !tmr_evt)
			begin
				// whole units of the chosen resolution, 1 to 7 of them
				if (tmr_sub_r == (tmr_res_r ? UNIT_L : UNIT_S))
				begin
					tmr_sub_r  <= 21'h000000;
					tmr_unit_r <= tmr_unit_r - 3'h1;
				end
				else
					tmr_sub_r <= tmr_sub_r + 21'h000001;
			end
		end
	end

	// wake cause flags; a set in the cycle of a clear wins
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			btn_flag_r         <= 1'b0;
			tmr_flag_r         <= 1'b0;
			power_return_irq_r <= 1'b0;
		end
		else if (ce)
		begin
			if (pin_s)
			begin
				btn_flag_r         <= 1'b0;
				tmr_flag_r         <= 1'b0;
				power_return_irq_r <= 1'b0;
			end
			else
			begin
				if (btn_evt)
					btn_flag_r <= 1'b1;
				else if (wr_flags && hwdata[`RFWS_FLAG_BTN])
					btn_flag_r <= 1'b0;
				if (tmr_evt && !btn_evt)
					tmr_flag_r <= 1'b1;
				else if (wr_flags && hwdata[`RFWS_FLAG_TMR])
					tmr_flag_r <= 1'b0;
				if (mode_r == ST_BATT && state_nxt == ST_FULL)
					power_return_irq_r <= 1'b1;
				else if (wr_flags && hwdata[`RFWS_FLAG_RET])
					power_return_irq_r <= 1'b0;
			end
		end
	end

	// ahb-lite address phase capture; the slave never inserts waits
	assign take = hsel && hready && htrans[1];

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			ap_valid_r <= 1'b0;
			ap_write_r <= 1'b0;
			ap_addr_r  <= 8'h00;
			hrdata     <= 32'h0000_0000;
			hreadyout  <= 1'b1;
			hresp      <= 1'b0;
		end
		else if (ce)
		begin
			ap_valid_r <= take;
			ap_write_r <= hwrite;
			ap_addr_r  <= haddr[7:0];
			hreadyout  <= 1'b1;
			hresp      <= 1'b0;
			if (take && !hwrite)
				hrdata <= rd_data;
		end
	end

	assign wr_ctrl   = ap_valid_r && ap_write_r &&
		ap_addr_r == `RFWS_CTRL_OFS && !pin_s;
	assign wr_flags  = ap_valid_r && ap_write_r && ap_addr_r == `RFWS_FLAGS_OFS;
	assign req_sleep = wr_ctrl && hwdata[`RFWS_CTRL_SLEEP];
	assign req_disp  = wr_ctrl && hwdata[`RFWS_CTRL_DISP];

	// read mux; unmapped offsets read zero
	always_comb
	begin
		rd_data = 32'h0000_0000;
		case (haddr[7:0])
			`RFWS_CTRL_OFS:
			begin
				rd_data[`RFWS_CTRL_ARM] = armed_r;
				rd_data[`RFWS_CTRL_RES] = res_r;
				rd_data[`RFWS_CTRL_PRD_HI:`RFWS_CTRL_PRD_LO] = prd_r;
				rd_data[`RFWS_CTRL_DIV_HI:`RFWS_CTRL_DIV_LO] = div_r;
			end
			`RFWS_STATUS_OFS:
			begin
				rd_data[`RFWS_STAT_MODE_HI:`RFWS_STAT_MODE_LO] = mode_r;
				rd_data[`RFWS_STAT_PLL]   = pll_locked_r;
				rd_data[`RFWS_STAT_CMP]   = pwr_s;
				rd_data[`RFWS_STAT_BAT]   = bat_s;
				rd_data[`RFWS_STAT_ARMED] = armed_r;
			end
			`RFWS_FLAGS_OFS:
			begin
				rd_data[`RFWS_FLAG_BTN] = btn_flag_r;
				rd_data[`RFWS_FLAG_TMR] = tmr_flag_r;
				rd_data[`RFWS_FLAG_RET] = power_return_irq_r;
			end
			default: rd_data = 32'h0000_0000;
		endcase
	end

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence s_batt_to_full;
		mode_r == ST_BATT ##1 mode_r == ST_FULL;
	endsequence

	sequence s_low_to_full;
		(mode_r == ST_DISP || mode_r == ST_SLEEP) ##1 mode_r == ST_FULL;
	endsequence

	a_reset_defaults: assert property (ce && pin_s |=> mode_r == ST_RESET
		&& !run_r && div_r == 3'h0) else $error("reset pin not obeyed");
	a_start_after_timer: assert property (ce && rst_done |=> run_r
		&& cpu_start_r) else $error("run not raised at timer end");
	a_fault_batt_run: assert property (ce && mode_r == ST_FULL && !pwr_s
		&& bat_s && !pin_s |=> mode_r == ST_BATT && run_r && !pll_locked_r)
		else $error("fault did not enter battery run");
	a_fault_no_battery: assert property (ce && run_r && !pwr_s && !bat_s
		&& !pin_s |=> !run_r && mode_r == ST_SLEEP)
		else $error("fault without battery kept running");
	a_full_needs_pll: assert property (mode_r == ST_FULL |-> pll_locked_r)
		else $error("full power without pll lock");
	a_return_irq: assert property (s_batt_to_full |-> ##1 power_return_irq_r
		&& $stable(div_r)) else $error("no interrupt on power return");
	a_low_cfg_clear: assert property (run_r ##1 (!run_r && mode_r != ST_RESET)
		|-> div_r == 3'h0 && prd_r == 3'h0) else $error("config kept in low mode");
	a_watchdog_on: assert property (s_low_to_full |-> ##1 watchdog_en_r)
		else $error("watchdog not enabled");
	a_button_wake: assert property (ce && btn_evt && !pin_s && !pll_locked_r
		|=> run_r && btn_flag_r && cpu_start_r)
		else $error("button did not wake");
	a_timer_wake: assert property (ce && tmr_evt && !btn_evt && !pin_s
		&& !pll_locked_r |=> run_r && tmr_flag_r && !armed_r)
		else $error("timer did not wake");
	a_batt_clock: assert property (ce && state_nxt == ST_BATT |=> cpu_slow_clk_r
		&& cpu_div_r == 3'h0) else $error("battery clock not selected");
endmodule

`default_nettype wire

/* File: tb/reset_fault_wake_sequencer_tb.sv */
// self-checking bench for the reset, fault and wake sequencer
`timescale 1ns/1ps
`default_nettype none

module reset_fault_wake_sequencer_tb;
	import rfws_pkg::*;
	localparam int RT = 8;
	localparam int PT = 4;
	localparam int WS = 6;
	localparam int WL = 12;
	localparam int TK = 8;
	// wake table entries: display request, resolution, period
	localparam logic [4:0] TW [3] = '{5'b00001, 5'b01011, 5'b10111};

	logic           hclk = 1'b0;
	logic           hresetn = 1'b0;
	logic [31:0]    haddr = 32'h0;
	logic [31:0]    hwdata = 32'h0;
	logic [1:0]     htrans = 2'h0;
	logic           hwrite = 1'b0;
	logic [31:0]    hrdata;
	logic           hreadyout;
	logic           hresp;
	logic           run_r;
	logic           cpu_start_r;
	rfws_state_type mode_r;
	logic           pll_locked_r;
	logic           watchdog_en_r;
	logic           cpu_slow_clk_r;
	logic [2:0]     cpu_div_r;
	logic           power_return_irq_r;
	wire logic      reset_pin;
	wire logic      fault_sense_input;
	wire logic      battery_good_flag;
	wire logic      pushbutton_input;
	wire logic      slow_crystal_clock;
	logic           want_pin = 1'b1;
	logic           want_power = 1'b1;
	logic           want_batt = 1'b1;
	logic           want_press = 1'b0;
	int             n_errors = 0;
	int             checks_done = 0;
	int             starts = 0;
	int             n;
	int             t;
	int             k0;
	logic [31:0]    v;

	rfws_sequencer #(.RESET_TICKS(RT), .PLL_SETTLE_TICKS(PT),
		.DEB_TICKS(4), .WAKE_SHORT_TICKS(WS), .WAKE_LONG_TICKS(WL)) uut
	(
		.hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(1'b1),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
		.hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .reset_pin(reset_pin),
		.fault_sense_input(fault_sense_input),
		.battery_good_flag(battery_good_flag),
		.pushbutton_input(pushbutton_input),
		.slow_crystal_clock(slow_crystal_clock), .run_r(run_r),
		.cpu_start_r(cpu_start_r), .mode_r(mode_r),
		.pll_locked_r(pll_locked_r), .watchdog_en_r(watchdog_en_r),
		.cpu_slow_clk_r(cpu_slow_clk_r), .cpu_div_r(cpu_div_r),
		.power_return_irq_r(power_return_irq_r)
	);

	rfws_far_side far
	(
		.hclk(hclk), .want_pin(want_pin), .want_power(want_power),
		.want_batt(want_batt), .want_press(want_press),
		.reset_pin(reset_pin), .fault_sense_input(fault_sense_input),
		.battery_good_flag(battery_good_flag),
		.pushbutton_input(pushbutton_input),
		.slow_crystal_clock(slow_crystal_clock)
	);

	// 250 MHz bus clock
	always #2 hclk = ~hclk;

	// count processor start pulses as they rise, so the count is settled
	// by the edge at which run is first seen high
	always @(posedge cpu_start_r)
		starts <= starts + 1;

	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// one ahb-lite single transfer, address phase then data phase
	task automatic bus(input logic wr, input logic [7:0] a,
		input logic [31:0] wd, output logic [31:0] rd);
		@(posedge hclk);
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= wr;
		repeat (2)
		begin
			@(posedge hclk);
			while (hreadyout !== 1'b1)
				@(posedge hclk);
			htrans <= 2'h0;
			hwdata <= wd;
		end
		rd = hrdata;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		bus(1'b1, a, d, x);
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		bus(1'b0, a, 32'h0, d);
	endtask

	// wait for a run level and mode, any mode when any is set
	task automatic wait_sig(input logic r, input logic any,
		input rfws_state_type m, input int lim, output int cnt);
		cnt = 0;
		while (!(run_r === r && (any || mode_r === m)) && cnt < lim)
		begin
			@(posedge hclk);
			cnt++;
		end
	endtask

	// the mode must not move for the whole span
	task automatic held(input string what, input rfws_state_type m,
		input int c);
		logic bad;
		bad = 1'b0;
		repeat (c)
		begin
			@(posedge hclk);
			if (mode_r !== m)
				bad = 1'b1;
		end
		check(what, bad, 1'b0);
	endtask

	task automatic wrap_up;
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// limit well above the few thousand cycles that the tests need
	initial
	begin
		#100000;
		n_errors++;
		wrap_up;
	end

	initial
	begin
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		check("pin reset mode", mode_r, ST_RESET);
		wr(8'h00, 32'h0000_0515);
		rd(8'h00, v);
		check("ctrl in pin reset", v, 32'h0);
		rd(8'h0C, v);
		check("unmapped read", v, 32'h0);
		check("okay response", {hreadyout, hresp}, 2'b10);
		want_pin <= 1'b0;
		wait_sig(1'b1, 1'b1, ST_FULL, 40 * TK, n);
		check("reset delay", n >= (RT - 1) * TK && n <= (RT + 2) * TK, 1);
		check("start pulse", starts, 1);
		wait_sig(1'b1, 1'b0, ST_FULL, 40 * TK, n);
		check("full after reset", mode_r, ST_FULL);
		$display("test reset done");

		wr(8'h00, 32'h0000_0500);
		// stored divider lands at the data edge, its use one edge later
		repeat (2) @(posedge hclk);
		check("divider in full", cpu_div_r, 3'h5);
		want_power <= 1'b0;
		wait_sig(1'b1, 1'b0, ST_BATT, 10 * TK, n);
		check("fault mode", mode_r, ST_BATT);
		check("fault lock", pll_locked_r, 1'b0);
		check("battery slow clock", cpu_slow_clk_r, 1'b1);
		check("battery divider", cpu_div_r, 3'h0);
		rd(8'h00, v);
		check("divider kept", v, 32'h0000_0500);
		want_power <= 1'b1;
		wait_sig(1'b1, 1'b0, ST_FULL, (PT + 6) * TK, n);
		check("lock wait", n >= (PT - 1) * TK, 1);
		check("return mode", mode_r, ST_FULL);
		check("return irq", power_return_irq_r, 1'b1);
		rd(8'h00, v);
		check("config kept", v, 32'h0000_0500);
		wr(8'h08, 32'h4);
		@(posedge hclk);
		check("irq cleared", power_return_irq_r, 1'b0);
		$display("test fault done");

		want_power <= 1'b0;
		wait_sig(1'b1, 1'b0, ST_BATT, 10 * TK, n);
		foreach (TW[i])
		begin
			wr(8'h00, 32'h501 | {TW[i][2:0], 2'b00} | {TW[i][3], 1'b0});
			repeat (4 * TK) @(posedge hclk);
			k0 = starts;
			wr(8'h00, TW[i][4] ? 32'h40 : 32'h20);
			repeat (2) @(posedge hclk);
			check("low mode", mode_r, TW[i][4] ? ST_DISP : ST_SLEEP);
			check("low run", run_r, 1'b0);
			t = int'(TW[i][2:0]) * (TW[i][3] ? WL : WS);
			wait_sig(1'b1, 1'b0, ST_BATT, (t + 4) * TK, n);
			check("wake time", n >= (t - 2) * TK && n <= (t + 2) * TK, 1);
			check("timer start", starts, k0 + 1);
			rd(8'h08, v);
			check("timer flag", v, 32'h2);
			rd(8'h00, v);
			check("config reset", v, 32'h0);
			wr(8'h08, 32'h2);
		end
		$display("test timer done");

		wr(8'h00, 32'h20);
		held("no rearm", ST_SLEEP, (WS + 4) * TK);
		want_press <= 1'b1;
		repeat (2 * TK) @(posedge hclk);
		want_press <= 1'b0;
		held("glitch", ST_SLEEP, 8 * TK);
		want_press <= 1'b1;
		wait_sig(1'b1, 1'b0, ST_BATT, 30 * TK, n);
		check("button wake", mode_r, ST_BATT);
		rd(8'h08, v);
		check("button flag", v, 32'h1);
		wr(8'h00, 32'h20);
		want_press <= 1'b0;
		repeat (10 * TK) @(posedge hclk);
		want_press <= 1'b1;
		held("press ignored", ST_SLEEP, 20 * TK);
		wr(8'h08, 32'h1);
		want_press <= 1'b0;
		repeat (10 * TK) @(posedge hclk);
		want_press <= 1'b1;
		wait_sig(1'b1, 1'b0, ST_BATT, 30 * TK, n);
		check("press after clear", mode_r, ST_BATT);
		want_press <= 1'b0;
		$display("test button done");

		wr(8'h08, 32'h7);
		want_power <= 1'b1;
		wait_sig(1'b1, 1'b0, ST_FULL, (PT + 6) * TK, n);
		want_batt <= 1'b0;
		want_power <= 1'b0;
		wait_sig(1'b0, 1'b0, ST_SLEEP, 10 * TK, n);
		check("no battery sleep", mode_r, ST_SLEEP);
		check("no battery run", run_r, 1'b0);
		want_power <= 1'b1;
		wait_sig(1'b1, 1'b0, ST_FULL, (PT + 8) * TK, n);
		check("power wake", mode_r, ST_FULL);
		check("watchdog", watchdog_en_r, 1'b1);
		rd(8'h08, v);
		check("no wake flags", v[1:0], 2'h0);
		rd(8'h04, v);
		check("comparator up", v[4], 1'b1);
		$display("test power return done");

		want_pin <= 1'b1;
		repeat (6) @(posedge hclk);
		check("pin mode", mode_r, ST_RESET);
		check("pin run", run_r, 1'b0);
		check("pin divider", cpu_div_r, 3'h0);
		want_power <= 1'b0;
		want_batt <= 1'b1;
		repeat (4 * TK) @(posedge hclk);
		want_pin <= 1'b0;
		wait_sig(1'b1, 1'b0, ST_BATT, 20 * TK, n);
		check("short reset mode", mode_r, ST_BATT);
		check("short reset time", n <= 5 * TK, 1);
		$display("test short reset done");
		wrap_up;
	end
endmodule

`default_nettype wire

/* File: tb/rfws_far_side.sv */
// far-side model: free-running crystal and board-level pin drivers
`timescale 1ns/1ps
`default_nettype none

module rfws_far_side
(
	// clock
	input  wire logic hclk,
	// levels the bench asks for
	input  wire logic want_pin,
	input  wire logic want_power,
	input  wire logic want_batt,
	input  wire logic want_press,
	// pins toward the sequencer
	output var  logic reset_pin,
	output var  logic fault_sense_input,
	output var  logic battery_good_flag,
	output var  logic pushbutton_input,
	output var  logic slow_crystal_clock
);
	logic [1:0] div_r = 2'h0;
	logic       xtal_r = 1'b0;

	// crystal never stops, not even in reset: it feeds the timers
	always_ff @(posedge hclk)
	begin
		div_r <= div_r + 2'h1;
		if (div_r == 2'h3)
			xtal_r <= ~xtal_r;
	end
	assign slow_crystal_clock = xtal_r;

	// pins settle one cycle after a request, like board wiring
	always_ff @(posedge hclk)
	begin
		reset_pin         <= want_pin;
		fault_sense_input <= want_power;
		battery_good_flag <= want_batt;
		pushbutton_input  <= want_press;
	end
endmodule

`default_nettype wire
